// File: rtl/dac_data_hold_and_trigger.sv
// Purpose: Register front end of a single-channel converter
// Assumes: Register port is synchronous, writes and reads take one cycle
// Notes:   Hardware trigger inputs are sampled as plain synchronous pulses
module dac_data_hold_and_trigger (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  // Register port
  input  wire logic        reg_sel_in,
  input  wire logic        reg_write_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  output logic      [31:0] reg_rdata_out,
  // Hardware trigger events, codes 0 to 6
  input  wire logic [6:0]  hw_trigger_in,
  // Converter core
  output logic      [11:0] output_sample_out
);
  typedef struct packed {
    logic              sw_trigger_bit;
    logic [11:0]       hold_sample;
    logic [11:0]       raw_r12;
    logic [11:0]       raw_l12;
    logic [7:0]        raw_r8;
    dac_hold_pkg::hold_src_e src;
    logic              trigger_enable_bit;
    logic [2:0]        trigger_source_sel;
    logic              pending;
    logic [31:0]       rdata;
  } front_s;
  front_s st_reg;
  front_s st_next;

  dac_hold_if link ();

  // Output data register lives in the stage
  dac_output_stage u_stage (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .link       (link.stage)
  );

  // Decode a write strobe for one offset
  function automatic logic wr_hit(input logic sel, input logic wr, input logic [7:0] a, input logic [7:0] off);
    wr_hit = sel && wr && (a == off);
  endfunction : wr_hit

  logic trig_event;
  logic load_now;

  // Selected trigger source
  always_comb begin
    if (st_reg.trigger_source_sel == dac_hold_pkg::SEL_SOFTWARE) begin
      trig_event = st_reg.sw_trigger_bit;
    end else begin
      trig_event = hw_trigger_in[st_reg.trigger_source_sel];
    end
  end

  // Transfer request: immediate when disabled, else on trigger
  assign load_now = st_reg.trigger_enable_bit ? (st_reg.pending && trig_event)
                                              : st_reg.pending;

  assign link.hold_sample = st_reg.hold_sample;
  assign link.load_now    = load_now;

  // Register writes, trigger clear and read mux
  always_comb begin
    st_next = st_reg;
    if (load_now) begin
      st_next.pending = 1'b0;
    end
    // Clear one cycle after the transfer
    if (link.loaded && st_reg.trigger_source_sel == dac_hold_pkg::SEL_SOFTWARE) begin
      st_next.sw_trigger_bit = 1'b0;
    end
    if (wr_hit(reg_sel_in, reg_write_in, reg_addr_in, dac_hold_pkg::OFF_CONTROL)) begin
      st_next.trigger_enable_bit = reg_wdata_in[dac_hold_pkg::TRIG_ENABLE_POS];
      st_next.trigger_source_sel = reg_wdata_in[dac_hold_pkg::TRIG_SEL_LSB +: 3];
    end
    if (wr_hit(reg_sel_in, reg_write_in, reg_addr_in, dac_hold_pkg::OFF_SOFT_TRIGGER)) begin
      st_next.sw_trigger_bit = reg_wdata_in[dac_hold_pkg::SW_TRIGGER_POS];
    end
    if (wr_hit(reg_sel_in, reg_write_in, reg_addr_in, dac_hold_pkg::OFF_HOLD_RIGHT12)) begin
      st_next.raw_r12     = reg_wdata_in[11:0];
      st_next.hold_sample = reg_wdata_in[11:0];
      st_next.src         = dac_hold_pkg::SRC_R12;
      st_next.pending     = 1'b1;
    end
    if (wr_hit(reg_sel_in, reg_write_in, reg_addr_in, dac_hold_pkg::OFF_HOLD_LEFT12)) begin
      st_next.raw_l12     = reg_wdata_in[dac_hold_pkg::LEFT12_LSB +: 12];
      st_next.hold_sample = reg_wdata_in[dac_hold_pkg::LEFT12_LSB +: 12];
      st_next.src         = dac_hold_pkg::SRC_L12;
      st_next.pending     = 1'b1;
    end
    if (wr_hit(reg_sel_in, reg_write_in, reg_addr_in, dac_hold_pkg::OFF_HOLD_RIGHT8)) begin
      st_next.raw_r8      = reg_wdata_in[7:0];
      st_next.hold_sample = {reg_wdata_in[7:0], 4'h0};
      st_next.src         = dac_hold_pkg::SRC_R8;
      st_next.pending     = 1'b1;
    end
    // Registered read data, reserved bits zero
    unique case (reg_addr_in)
      dac_hold_pkg::OFF_CONTROL:
        st_next.rdata = {26'h0, st_reg.trigger_source_sel, st_reg.trigger_enable_bit, 2'h0};
      dac_hold_pkg::OFF_SOFT_TRIGGER: st_next.rdata = {31'h0, st_reg.sw_trigger_bit};
      dac_hold_pkg::OFF_HOLD_RIGHT12: st_next.rdata = {20'h0, st_reg.raw_r12};
      dac_hold_pkg::OFF_HOLD_LEFT12:  st_next.rdata = {16'h0, st_reg.raw_l12, 4'h0};
      dac_hold_pkg::OFF_HOLD_RIGHT8:  st_next.rdata = {24'h0, st_reg.raw_r8};
      dac_hold_pkg::OFF_OUTPUT_VALUE: st_next.rdata = {20'h0, link.output_sample};
      default:                        st_next.rdata = dac_hold_pkg::RESET_WORD;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      st_reg     <= '0;
      st_reg.src <= dac_hold_pkg::SRC_R12;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_out     = st_reg.rdata;
  assign output_sample_out = link.output_sample;

  // Checks
  property p_untrig_copy;
    @(posedge clk_sys_in) disable iff (reset_in)
      (st_reg.pending && !st_reg.trigger_enable_bit) |=> (output_sample_out == $past(st_reg.hold_sample));
  endproperty
  a_untrig_copy: assert property (p_untrig_copy) else $error("hold not copied");

  property p_sw_clear;
    @(posedge clk_sys_in) disable iff (reset_in)
      (load_now && st_reg.trigger_source_sel == 3'h7 && !reg_sel_in) ##1 !reg_sel_in |=> !st_reg.sw_trigger_bit;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("trigger bit not cleared");

  property p_wait_trigger;
    @(posedge clk_sys_in) disable iff (reset_in)
      (st_reg.trigger_enable_bit && !trig_event) |=> $stable(output_sample_out);
  endproperty
  a_wait_trigger: assert property (p_wait_trigger) else $error("output moved without trigger");

  property p_sw_source;
    @(posedge clk_sys_in) disable iff (reset_in)
      (st_reg.trigger_enable_bit && st_reg.pending && st_reg.sw_trigger_bit && st_reg.trigger_source_sel == 3'h7)
        |=> (output_sample_out == $past(st_reg.hold_sample));
  endproperty
  a_sw_source: assert property (p_sw_source) else $error("software source ignored");

  property p_r8_place;
    @(posedge clk_sys_in) disable iff (reset_in)
      wr_hit(reg_sel_in, reg_write_in, reg_addr_in, dac_hold_pkg::OFF_HOLD_RIGHT8)
        |=> (st_reg.hold_sample == {$past(reg_wdata_in[7:0]), 4'h0});
  endproperty
  a_r8_place: assert property (p_r8_place) else $error("8-bit sample misplaced");

  property p_l12_take;
    @(posedge clk_sys_in) disable iff (reset_in)
      wr_hit(reg_sel_in, reg_write_in, reg_addr_in, 8'h0c) |=> (st_reg.hold_sample == $past(reg_wdata_in[15:4]));
  endproperty
  a_l12_take: assert property (p_l12_take) else $error("left sample wrong");

  property p_r12_take;
    @(posedge clk_sys_in) disable iff (reset_in)
      wr_hit(reg_sel_in, reg_write_in, reg_addr_in, 8'h08) |=> (st_reg.raw_r12 == $past(reg_wdata_in[11:0]));
  endproperty
  a_r12_take: assert property (p_r12_take) else $error("right sample wrong");

  property p_out_ro;
    @(posedge clk_sys_in) disable iff (reset_in)
      (wr_hit(reg_sel_in, reg_write_in, reg_addr_in, 8'h2c) && !load_now) |=> $stable(output_sample_out);
  endproperty
  a_out_ro: assert property (p_out_ro) else $error("output register written");

  property p_reset_zero;
    @(posedge clk_sys_in)
      reset_in |=> (st_reg.sw_trigger_bit == 1'b0 && st_reg.raw_r12 == 12'h000
        && st_reg.raw_l12 == 12'h000 && st_reg.raw_r8 == 8'h00
        && output_sample_out == 12'h000);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

  property p_r8_take;
    @(posedge clk_sys_in) disable iff (reset_in)
      wr_hit(reg_sel_in, reg_write_in, reg_addr_in, dac_hold_pkg::OFF_HOLD_RIGHT8)
        |=> (st_reg.raw_r8 == $past(reg_wdata_in[7:0]));
  endproperty
  a_r8_take: assert property (p_r8_take) else $error("byte sample wrong");

  property p_hold_src;
    @(posedge clk_sys_in) disable iff (reset_in)
      (st_reg.src == dac_hold_pkg::SRC_R12 && st_reg.hold_sample == st_reg.raw_r12)
        || (st_reg.src == dac_hold_pkg::SRC_L12 && st_reg.hold_sample == st_reg.raw_l12)
        || (st_reg.src == dac_hold_pkg::SRC_R8 && st_reg.hold_sample == {st_reg.raw_r8, 4'h0});
  endproperty
  a_hold_src: assert property (p_hold_src) else $error("hold sample disagrees with source");

  property p_sw_hold;
    @(posedge clk_sys_in) disable iff (reset_in)
      (load_now && !link.loaded && st_reg.sw_trigger_bit && !reg_sel_in
        && st_reg.trigger_source_sel == dac_hold_pkg::SEL_SOFTWARE)
        |=> st_reg.sw_trigger_bit;
  endproperty
  a_sw_hold: assert property (p_sw_hold) else $error("trigger bit cleared too early");

  property p_rd_out;
    @(posedge clk_sys_in) disable iff (reset_in)
      (reg_addr_in == dac_hold_pkg::OFF_OUTPUT_VALUE) |=> (reg_rdata_out == {20'h0, $past(output_sample_out)});
  endproperty
  a_rd_out: assert property (p_rd_out) else $error("output read wrong");
endmodule : dac_data_hold_and_trigger

// File: rtl/dac_hold_if.sv
// Purpose: Carries the sample and trigger between front end and staging stage
// Assumes: One clock domain
// Notes:   Front end drives requests, stage drives output value
interface dac_hold_if;
  logic [11:0] hold_sample;
  logic        load_now;
  logic [11:0] output_sample;
  logic        loaded;
  modport front (output hold_sample, output load_now, input output_sample, input loaded);
  modport stage (input hold_sample, input load_now, output output_sample, output loaded);
endinterface : dac_hold_if

// File: rtl/dac_hold_pkg.sv
// Purpose: Shared constants for the converter data-hold and trigger block
// Assumes: Registers sit at byte offsets on a simple peripheral register port
// Notes:   Control bits live in a block-owned register at offset 0x00
package dac_hold_pkg;
  // Register offsets
  localparam logic [7:0] OFF_CONTROL      = 8'h00;
  localparam logic [7:0] OFF_SOFT_TRIGGER = 8'h04;
  localparam logic [7:0] OFF_HOLD_RIGHT12 = 8'h08;
  localparam logic [7:0] OFF_HOLD_LEFT12  = 8'h0c;
  localparam logic [7:0] OFF_HOLD_RIGHT8  = 8'h10;
  localparam logic [7:0] OFF_OUTPUT_VALUE = 8'h2c;
  // Field positions
  localparam int SW_TRIGGER_POS  = 0;
  localparam int TRIG_ENABLE_POS = 2;
  localparam int TRIG_SEL_LSB    = 3;
  localparam int LEFT12_LSB      = 4;
  // Reset values and codes
  localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
  localparam logic [2:0]  SEL_SOFTWARE = 3'h7;
  // Which hold register was written last
  typedef enum logic [2:0] {
    SRC_R12 = 3'b001,
    SRC_L12 = 3'b010,
    SRC_R8  = 3'b100
  } hold_src_e;
endpackage : dac_hold_pkg

// File: rtl/dac_output_stage.sv
// Purpose: Output data register feeding the converter core
// Assumes: load_now is a one-cycle or level request
// Notes:   loaded pulses the cycle after a transfer
module dac_output_stage (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  // Link to front end
  dac_hold_if.stage link
);
  typedef struct packed {
    logic [11:0] value;
    logic        loaded;
  } stage_s;
  stage_s st_reg;
  stage_s st_next;

  // Capture the hold sample on request
  always_comb begin
    st_next        = st_reg;
    st_next.loaded = link.load_now;
    if (link.load_now) begin
      st_next.value = link.hold_sample;
    end
  end

  // State register
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.output_sample = st_reg.value;
  assign link.loaded        = st_reg.loaded;
endmodule : dac_output_stage

// File: tb/conv_core_model.sv
// Purpose: Behavioural converter core fed by the output register
// Assumes: One clock, synchronous active-high reset
// Notes:   Settles on each new code one cycle late
module conv_core_model (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  // Code from the output register
  input  wire logic [11:0] sample_in,
  // Code being converted
  output logic      [11:0] level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Latch the driven code as the analog level
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      level_out <= 12'h000;
    end else begin
      level_out <= sample_in;
    end
  end
endmodule : conv_core_model

// File: tb/tb_dac_data_hold_and_trigger.sv
// Purpose: Self-checking bench for the data-hold and trigger block
// Assumes: Trigger control word at offset 0x00
// Notes:   Reserved bits are always written as zero
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_dac_data_hold_and_trigger;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in;
  logic        reset_in;
  logic        reg_sel_in;
  logic        reg_write_in;
  logic [7:0]  reg_addr_in;
  logic [31:0] reg_wdata_in;
  logic [31:0] reg_rdata_out;
  logic [6:0]  hw_trigger_in;
  logic [11:0] output_sample_out;
  logic [11:0] core_level;
  logic [7:0]  offs [5] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h2c};
  int          miscompares = 0;
  int          tests_run = 0;
  int          cycles = 0;
  dac_data_hold_and_trigger i_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .reg_sel_in(reg_sel_in),
    .reg_write_in(reg_write_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .hw_trigger_in(hw_trigger_in), .output_sample_out(output_sample_out));
  conv_core_model i_core (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .sample_in(output_sample_out),
    .level_out(core_level));
  // Verdict and end of run
  task automatic end_sim;
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  // One register write, callers keep reserved bits zero
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_sel_in   <= 1'b1;
    reg_write_in <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_sel_in   <= 1'b0;
    reg_write_in <= 1'b0;
  endtask : wr
  // One register read and compare
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
    @(posedge clk_sys_in);
    reg_sel_in  <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_sel_in <= 1'b0;
    #1;
    `CHK(nm, ex, reg_rdata_out)
  endtask : chk_rd
  // Hold write with trigger off, output due two edges on
  task automatic put(input logic [7:0] a, input logic [31:0] d, input logic [11:0] ex);
    wr(a, d);
    @(posedge clk_sys_in);
    #1;
    `CHK("direct load", ex, output_sample_out)
  endtask : put
  // Bounded wait for the output code
  task automatic wait_out(input logic [11:0] ex);
    for (int n = 0; n < 8 && output_sample_out !== ex; n++) begin
      @(posedge clk_sys_in);
      #1;
    end
    `CHK("triggered load", ex, output_sample_out)
  endtask : wait_out
  // Clock
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // Hang guard
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_sim();
    end
  end
  // Main sequence
  initial begin
    reset_in = 1'b1;
    reg_sel_in = 1'b0;
    reg_write_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0;
    hw_trigger_in = 7'h00;
    repeat (16) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    foreach (offs[i]) chk_rd("reset value", offs[i], 32'h0);
    put(8'h08, 32'h0000_0123, 12'h123);
    chk_rd("right12", 8'h08, 32'h0000_0123);
    put(8'h0c, 32'h0000_abc0, 12'habc);
    chk_rd("left12", 8'h0c, 32'h0000_abc0);
    put(8'h10, 32'h0000_005a, 12'h5a0);
    chk_rd("right8", 8'h10, 32'h0000_005a);
    `CHK("core level", 12'h5a0, core_level)
    wr(8'h2c, 32'h0000_0777);
    chk_rd("output read", 8'h2c, 32'h0000_05a0);
    chk_rd("unmapped", 8'h20, 32'h0);
    // Every hardware source code, output held until its trigger
    for (int i = 0; i < 7; i++) begin
      wr(8'h00, 32'(i << 3) | 32'h4);
      wr(8'h08, 32'h100 + 32'(i));
      repeat (3) @(posedge clk_sys_in);
      #1;
      `CHK("held before trigger", (i == 0) ? 12'h5a0 : 12'h0ff + 12'(i), output_sample_out)
      @(posedge clk_sys_in);
      hw_trigger_in <= 7'(1 << i);
      @(posedge clk_sys_in);
      hw_trigger_in <= 7'h00;
      wait_out(12'h100 + 12'(i));
    end
    wr(8'h00, 32'h0000_003c);
    chk_rd("control", 8'h00, 32'h0000_003c);
    wr(8'h08, 32'h0000_0321);
    repeat (3) @(posedge clk_sys_in);
    #1;
    `CHK("wait for soft", 12'h106, output_sample_out)
    wr(8'h04, 32'h1);
    wait_out(12'h321);
    chk_rd("soft cleared", 8'h04, 32'h0);
    wr(8'h00, 32'h0000_001c);
    wr(8'h04, 32'h1);
    chk_rd("soft set", 8'h04, 32'h1);
    wr(8'h04, 32'h0);
    chk_rd("soft withdrawn", 8'h04, 32'h0);
    // Mid-run reset drops armed trigger and waiting sample
    wr(8'h04, 32'h1);
    wr(8'h10, 32'h0000_0033);
    @(posedge clk_sys_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    foreach (offs[i]) chk_rd("reset again", offs[i], 32'h0);
    chk_rd("control reset", 8'h00, 32'h0);
    put(8'h0c, 32'h0000_4560, 12'h456);
    end_sim();
  end
endmodule : tb_dac_data_hold_and_trigger
